// *** design/pmrr_regs.sv ***
/*
  Result register bank of a current and power monitor: calibration and
  drift coefficient storage, averaged result capture, energy overflow flag.
  Assumes a serial framer on mclk issuing one-cycle read and write strobes,
  and a converter core on mclk delivering one-cycle sample strobes.
*/
`timescale 1ns/10ps
module pmrr_regs (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // Register access from the serial framer
  input  wire logic [pmrr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                         reg_wr_en,
  input  wire logic [pmrr_pkg::WDATA_W-1:0] reg_wdata,
  input  wire logic                         reg_rd_en,
  output logic [pmrr_pkg::RDATA_W-1:0]      reg_rdata,
  output logic                              reg_rd_valid,
  // Configuration bits
  input  wire logic                         shunt_range_select,
  input  wire logic                         drift_compensation_enable,
  input  wire logic [pmrr_pkg::AVG_W-1:0]   averaging_count,
  // Samples from the converter core
  input  wire logic                         smp_valid,
  input  wire logic [pmrr_pkg::RES_W-1:0]   smp_shunt,
  input  wire logic [pmrr_pkg::RES_W-1:0]   smp_bus,
  input  wire logic [pmrr_pkg::TEMP_W-1:0]  smp_temp,
  input  wire logic [pmrr_pkg::RES_W-1:0]   calc_current,
  input  wire logic [pmrr_pkg::PWR_W-1:0]   calc_power,
  input  wire logic [pmrr_pkg::ACC_W-1:0]   calc_energy,
  input  wire logic [pmrr_pkg::ACC_W-1:0]   calc_charge,
  input  wire logic                         energy_wrap,
  // Settings toward the converter core
  output logic [pmrr_pkg::CAL_W-1:0]        core_shunt_cal,
  output logic [pmrr_pkg::COEFF_W-1:0]      core_drift_coeff,
  output logic                              core_shunt_range,
  // Status toward the alert logic
  output logic                              result_range,
  output logic                              result_update,
  output logic                              energy_overflow_flag
);
  import pmrr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CAL_W-1:0]   cal;
    logic [COEFF_W-1:0] coeff;
    logic [COEFF_W-1:0] core_coeff;
    logic               core_range;
    logic [RES_W-1:0]   shunt_voltage_result;
    logic [RES_W-1:0]   bus_voltage_result;
    logic [TEMP_W-1:0]  dtemp;
    logic [RES_W-1:0]   curr;
    logic [PWR_W-1:0]   pwr;
    logic [ACC_W-1:0]   energy;
    logic [ACC_W-1:0]   charge;
    logic               res_range;
    logic               upd;
    logic               eof;
    logic [RDATA_W-1:0] rdata;
    logic               rd_valid;
  } pmrr_state_s;

  pmrr_state_s          q;
  pmrr_state_s          d;
  logic [SHIFT_W-1:0]   shift;
  logic                 shunt_avg_valid;
  logic [RES_W-1:0]     shunt_avg;
  logic [RES_W-1:0]     bus_avg;
  logic [TEMP_W-1:0]    temp_avg;
  logic [RDATA_W-1:0]   mux_rdata;

  assign shift = avg_shift(averaging_count);

  // ---------------------------------------------------------------
  // Averagers
  // ---------------------------------------------------------------
  // All three share the sample strobe, so they complete together and
  // the shunt instance alone paces the capture.
  pmrr_avg #(.W(RES_W)) u_avg_shunt (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .smp_valid (smp_valid),
    .smp       (smp_shunt),
    .shift     (shift),
    .avg_valid (shunt_avg_valid),
    .avg       (shunt_avg)
  );

  pmrr_avg #(.W(RES_W)) u_avg_bus (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .smp_valid (smp_valid),
    .smp       (smp_bus),
    .shift     (shift),
    .avg_valid (),
    .avg       (bus_avg)
  );

  pmrr_avg #(.W(TEMP_W)) u_avg_temp (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .smp_valid (smp_valid),
    .smp       (smp_temp),
    .shift     (shift),
    .avg_valid (),
    .avg       (temp_avg)
  );

  // ---------------------------------------------------------------
  // Read selection
  // ---------------------------------------------------------------
  pmrr_rdmux u_rdmux (
    .addr   (reg_addr),
    .cal    (q.cal),
    .coeff  (q.coeff),
    .shunt_voltage_result (q.shunt_voltage_result),
    .bus_voltage_result   (q.bus_voltage_result),
    .dtemp  (q.dtemp),
    .curr   (q.curr),
    .pwr    (q.pwr),
    .energy (q.energy),
    .charge (q.charge),
    .rdata  (mux_rdata)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d          = q;
    d.upd      = 1'b0;
    d.rd_valid = 1'b0;
    d.core_range = shunt_range_select;
    // Without compensation the core sees a zero coefficient
    d.core_coeff = drift_compensation_enable ? q.coeff : COEFF_RST;
    if (reg_wr_en) begin
      // Only the two writable fields take data; upper bits are dropped
      if (reg_addr == ADDR_CAL) begin
        d.cal = reg_wdata[CAL_W-1:0];
      end else if (reg_addr == ADDR_COEFF) begin
        d.coeff = reg_wdata[COEFF_W-1:0];
      end
    end
    if (shunt_avg_valid) begin
      // Every result moves in one edge, so no read sees a mixed set
      d.shunt_voltage_result    = shunt_avg;
      d.bus_voltage_result      = bus_avg;
      d.dtemp     = temp_avg;
      d.curr      = calc_current;
      d.pwr       = calc_power;
      d.energy    = calc_energy;
      d.charge    = calc_charge;
      d.res_range = q.core_range;
      d.upd       = 1'b1;
    end
    if (reg_rd_en) begin
      d.rdata    = mux_rdata;
      d.rd_valid = 1'b1;
    end
    if (reg_rd_en && (reg_addr == ADDR_ENERGY)) begin
      d.eof = 1'b0;
    end
    // A wrap in the same cycle as the clearing read is kept
    if (energy_wrap) begin
      d.eof = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q     <= '0;
      q.cal <= CAL_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata            = q.rdata;
  assign reg_rd_valid         = q.rd_valid;
  assign core_shunt_cal       = q.cal;
  assign core_drift_coeff     = q.core_coeff;
  assign core_shunt_range     = q.core_range;
  assign result_range         = q.res_range;
  assign result_update        = q.upd;
  assign energy_overflow_flag = q.eof;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_CAL_RESET: assert property (
    $rose(rst_n) |-> core_shunt_cal == CAL_RST && q.coeff == COEFF_RST)
    else $error("calibration or coefficient not at reset value");

  AST_CAL_WRITE: assert property (
    reg_wr_en && reg_addr == ADDR_CAL
      |=> core_shunt_cal == $past(reg_wdata[CAL_W-1:0]))
    else $error("calibration write not passed to core");

  AST_COEFF_WRITE: assert property (
    reg_wr_en && reg_addr == ADDR_COEFF
      |=> q.coeff == $past(reg_wdata[COEFF_W-1:0]))
    else $error("coefficient write not stored");

  AST_SHUNT_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_SHUNT
      |=> reg_rdata == {16'h0, $past(q.shunt_voltage_result), 4'h0})
    else $error("shunt result not placed in bits 23 to 4");

  AST_RANGE_TAG: assert property (
    shunt_avg_valid |=> result_range == $past(core_shunt_range))
    else $error("result range does not follow range in effect");

  AST_RANGE_FWD: assert property (
    1'b1 |=> core_shunt_range == $past(shunt_range_select))
    else $error("range select not forwarded");

  AST_COMP_OFF: assert property (
    !drift_compensation_enable |=> core_drift_coeff == COEFF_RST)
    else $error("coefficient applied while compensation disabled");

  AST_COMP_ON: assert property (
    drift_compensation_enable |=> core_drift_coeff == $past(q.coeff))
    else $error("coefficient withheld while compensation enabled");

  AST_TOP_ZERO: assert property (
    reg_rd_en && reg_addr == ADDR_CAL |=> reg_rdata[RDATA_W-1:CAL_W] == '0)
    else $error("reserved calibration bits not zero");

  AST_LOW_ZERO: assert property (
    reg_rd_en && (reg_addr == ADDR_BUS || reg_addr == ADDR_CURR)
      |=> reg_rdata[RES_LSB-1:0] == 4'h0 && reg_rdata[RDATA_W-1:24] == 16'h0)
    else $error("reserved result bits not zero");

  AST_HOLD: assert property (
    !shunt_avg_valid |=> $stable(q.shunt_voltage_result) && $stable(q.energy) && !result_update)
    else $error("results changed without a completed average");

  AST_CAPTURE: assert property (
    shunt_avg_valid |=> q.energy == $past(calc_energy)
      && q.charge == $past(calc_charge) && q.pwr == $past(calc_power)
      && q.curr == $past(calc_current) && result_update)
    else $error("results not captured together");

  AST_RO_WRITE: assert property (
    reg_wr_en && reg_addr == ADDR_POWER && !shunt_avg_valid
      |=> $stable(q.pwr) && $stable(core_shunt_cal))
    else $error("write to read-only register took effect");

  AST_EOF_SET: assert property (
    energy_wrap |=> energy_overflow_flag [*1] ##0 1'b1)
    else $error("energy overflow flag not set");

  AST_EOF_CLR: assert property (
    reg_rd_en && reg_addr == ADDR_ENERGY && !energy_wrap
      |=> !energy_overflow_flag)
    else $error("energy overflow flag not cleared by read");

  AST_EOF_KEEP: assert property (
    energy_overflow_flag && !(reg_rd_en && reg_addr == ADDR_ENERGY)
      |=> energy_overflow_flag)
    else $error("energy overflow flag lost without a read");

  AST_RD_LAT: assert property (
    reg_rd_en |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_en)))
    else $error("read answer not one cycle after request");

  AST_BUS_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_BUS
      |=> reg_rdata == {16'h0, $past(q.bus_voltage_result), 4'h0})
    else $error("bus result misplaced");

  AST_TEMP_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_TEMP
      |=> reg_rdata == {24'h0, $past(q.dtemp)})
    else $error("temperature result misplaced");

  AST_CURR_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_CURR
      |=> reg_rdata == {16'h0, $past(q.curr), 4'h0})
    else $error("current result misplaced");

  AST_POWER_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_POWER
      |=> reg_rdata == {16'h0, $past(q.pwr)})
    else $error("power result misplaced");

  AST_ENERGY_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_ENERGY
      |=> reg_rdata == $past(q.energy))
    else $error("energy result misplaced");

  AST_CHARGE_FIELD: assert property (
    reg_rd_en && reg_addr == ADDR_CHARGE
      |=> reg_rdata == $past(q.charge))
    else $error("charge result misplaced");

  AST_UNMAPPED: assert property (
    reg_rd_en && (reg_addr < ADDR_CAL || reg_addr > ADDR_CHARGE)
      |=> reg_rdata == '0)
    else $error("unmapped read not zero");

  AST_RES_RESET: assert property (
    $rose(rst_n)
      |-> q.dtemp == '0 && q.curr == '0 && q.charge == '0 && !energy_overflow_flag)
    else $error("results not cleared by reset");

  AST_RANGE_HOLD: assert property (
    !shunt_avg_valid
      |=> $stable(result_range))
    else $error("result range changed without capture");

  AST_CHG_HOLD: assert property (
    !shunt_avg_valid
      |=> $stable(q.charge) && $stable(q.curr) && $stable(q.pwr))
    else $error("results changed between captures");

  AST_AVG_CAPTURE: assert property (
    shunt_avg_valid
      |=> q.bus_voltage_result == $past(bus_avg) && q.dtemp == $past(temp_avg))
    else $error("averaged results not captured");

  COV_AVG_UPDATE: cover property (
    averaging_count == 3'h1 && smp_valid ##[1:40] result_update);

  COV_EOF_READ: cover property (
    energy_overflow_flag ##1 reg_rd_en && reg_addr == ADDR_ENERGY);

  COV_CAL_RW: cover property (
    reg_wr_en && reg_addr == ADDR_CAL ##1 reg_rd_en && reg_addr == ADDR_CAL);

  COV_WRAP_ON_CLEAR: cover property (
    energy_wrap && reg_rd_en && reg_addr == ADDR_ENERGY);

endmodule : pmrr_regs

// *** design/pmrr_pkg.sv ***
/*
  Constants shared by the power monitor result register bank: register
  addresses, field widths and positions, reset values and the averaging
  decode. Assumes the serial framer presents a 6-bit register address.
*/
// Overview of operation
// - Calibration holds 15 writable low bits, resetting to 1000h
// - Calibration value is sent to the core to set current resolution
// - Drift coefficient holds 14 writable bits, resets to zero, 1 ppm per LSB
// - Shunt result is 20-bit signed, in bits 23 to 4, read-only
// - Shunt result scale follows the range in effect for that result
// - Bus result is 20-bit signed, never negative, bits 23 to 4, read-only
// - Die temperature result is 16-bit signed, read-only, resets to zero
// - Current result is 20-bit signed in bits 23 to 4, resets to zero
// - Power result is 24-bit unsigned over bits 23 to 0, resets to zero
// - Energy result is 40-bit unsigned, read-only
// - Charge result is 40-bit signed, read-only, resets to zero
// - Reserved bit positions always read as zero
// - Range select picks 163.84 mV or 40.96 mV full scale
// - Compensation enable decides whether the drift coefficient is applied
// - Results update only after the selected sample count is averaged
// - Energy overflow sets a flag, cleared by reading the energy result
package pmrr_pkg;

  localparam int ADDR_W  = 6;
  localparam int WDATA_W = 16;
  localparam int RDATA_W = 40;
  localparam int CAL_W   = 15;
  localparam int COEFF_W = 14;
  localparam int RES_W   = 20;
  localparam int RES_LSB = 4;
  localparam int TEMP_W  = 16;
  localparam int PWR_W   = 24;
  localparam int ACC_W   = 40;
  localparam int AVG_W   = 3;
  localparam int SHIFT_W = 4;
  localparam int CNT_W   = 10;

  localparam logic [ADDR_W-1:0] ADDR_CAL    = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_COEFF  = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_SHUNT  = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_BUS    = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_TEMP   = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_CURR   = 6'h07;
  localparam logic [ADDR_W-1:0] ADDR_POWER  = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY = 6'h09;
  localparam logic [ADDR_W-1:0] ADDR_CHARGE = 6'h0a;

  localparam logic [CAL_W-1:0]   CAL_RST   = 15'h1000;
  localparam logic [COEFF_W-1:0] COEFF_RST = 14'h0;

  // Averaging code to log2 of the sample count: 1,4,16,64,128,256,512,1024
  function automatic logic [SHIFT_W-1:0] avg_shift(input logic [AVG_W-1:0] code);
    case (code)
      3'h0:    avg_shift = 4'h0;
      3'h1:    avg_shift = 4'h2;
      3'h2:    avg_shift = 4'h4;
      3'h3:    avg_shift = 4'h6;
      3'h4:    avg_shift = 4'h7;
      3'h5:    avg_shift = 4'h8;
      3'h6:    avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction : avg_shift

endpackage : pmrr_pkg

// *** design/pmrr_avg.sv ***
/*
  Signed sample averager for one converter channel.
  Assumes samples arrive as single-cycle strobes on mclk.
*/
`timescale 1ns/10ps
module pmrr_avg #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // Samples and averaging setting
  input  wire logic                         smp_valid,
  input  wire logic [W-1:0]                 smp,
  input  wire logic [pmrr_pkg::SHIFT_W-1:0] shift,
  // Averaged result
  output logic                              avg_valid,
  output logic [W-1:0]                      avg
);
  import pmrr_pkg::*;

  typedef struct packed {
    logic signed [W+CNT_W-1:0] acc;
    logic [CNT_W-1:0]          cnt;
    logic                      vld;
    logic [W-1:0]              avg;
  } pmrr_avg_s;

  pmrr_avg_s               q;
  pmrr_avg_s               d;
  logic signed [W+CNT_W-1:0] sum;
  logic [CNT_W-1:0]        lim;

  always_comb begin
    d   = q;
    d.vld = 1'b0;
    lim = CNT_W'((11'h1 << shift) - 11'h1);
    sum = q.acc + {{CNT_W{smp[W-1]}}, smp};
    if (smp_valid) begin
      // At or past the limit, so a smaller setting mid-run still completes
      if (q.cnt >= lim) begin
        d.avg = W'(sum >>> shift);
        d.vld = 1'b1;
        d.acc = '0;
        d.cnt = '0;
      end else begin
        d.acc = sum;
        d.cnt = CNT_W'(q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign avg_valid = q.vld;
  assign avg       = q.avg;

endmodule : pmrr_avg

// *** design/pmrr_rdmux.sv ***
/*
  Read data selection for the result register bank.
  Assumes all inputs come from flip-flops of the same clock.
*/
`timescale 1ns/10ps
module pmrr_rdmux (
  // Address
  input  wire logic [pmrr_pkg::ADDR_W-1:0]  addr,
  // Stored fields
  input  wire logic [pmrr_pkg::CAL_W-1:0]   cal,
  input  wire logic [pmrr_pkg::COEFF_W-1:0] coeff,
  input  wire logic [pmrr_pkg::RES_W-1:0]   shunt_voltage_result,
  input  wire logic [pmrr_pkg::RES_W-1:0]   bus_voltage_result,
  input  wire logic [pmrr_pkg::TEMP_W-1:0]  dtemp,
  input  wire logic [pmrr_pkg::RES_W-1:0]   curr,
  input  wire logic [pmrr_pkg::PWR_W-1:0]   pwr,
  input  wire logic [pmrr_pkg::ACC_W-1:0]   energy,
  input  wire logic [pmrr_pkg::ACC_W-1:0]   charge,
  // Read word, zero-padded; shunt, bus and current sit at bits 23 to 4
  output logic [pmrr_pkg::RDATA_W-1:0]      rdata
);
  import pmrr_pkg::*;

  always_comb begin
    // Padding bits are constant zero, never storage
    if (addr == ADDR_CAL) begin
      rdata = {25'h0, cal};
    end else if (addr == ADDR_COEFF) begin
      rdata = {26'h0, coeff};
    end else if (addr == ADDR_SHUNT) begin
      rdata = {16'h0, shunt_voltage_result, 4'h0};
    end else if (addr == ADDR_BUS) begin
      rdata = {16'h0, bus_voltage_result, 4'h0};
    end else if (addr == ADDR_TEMP) begin
      rdata = {24'h0, dtemp};
    end else if (addr == ADDR_CURR) begin
      rdata = {16'h0, curr, 4'h0};
    end else if (addr == ADDR_POWER) begin
      rdata = {16'h0, pwr};
    end else if (addr == ADDR_ENERGY) begin
      rdata = energy;
    end else if (addr == ADDR_CHARGE) begin
      rdata = charge;
    end else begin
      rdata = '0;
    end
  end

endmodule : pmrr_rdmux

// *** sim/pmrr_host_model.sv ***
/*
  Behavioural host for the result register bank: issues single register
  writes and reads on the parallel strobe port.
  Assumes mclk from the bench; requests change on the falling edge.
*/
`timescale 1ns/10ps
module pmrr_host_model (
  // Clock
  input  wire logic                         mclk,
  // Register port toward the bank
  output logic [pmrr_pkg::ADDR_W-1:0]       reg_addr,
  output logic                              reg_wr_en,
  output logic [pmrr_pkg::WDATA_W-1:0]      reg_wdata,
  output logic                              reg_rd_en,
  input  wire logic [pmrr_pkg::RDATA_W-1:0] reg_rdata,
  input  wire logic                         reg_rd_valid
);
  import pmrr_pkg::*;

  initial begin
    reg_addr  = 6'h3f;
    reg_wr_en = 1'b0;
    reg_wdata = 16'ha5a5;
    reg_rd_en = 1'b0;
  end

  // --------------------------------------------------------------------
  // Transfers
  // --------------------------------------------------------------------
  // Idle address and data show the inverse of the last value, so a bank
  // that samples them outside a strobe cannot pass by luck
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WDATA_W-1:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [RDATA_W-1:0] d,
                    output logic v);
    @(negedge mclk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge mclk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d         = reg_rdata;
    v         = reg_rd_valid;
  endtask : rd

endmodule : pmrr_host_model

// *** sim/pmrr_regs_tb_top.sv ***
/*
  Self-checking bench for the result register bank: register table,
  calibration and drift settings, averaged capture, energy overflow flag.
  Assumes the host model drives the register port; the bench plays the core.
*/
`timescale 1ns/10ps
module pmrr_regs_tb_top;
  import pmrr_pkg::*;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic [39:0]       exp;
  } pmrr_row_s;

  logic                mclk, rst_n;
  logic [ADDR_W-1:0]   reg_addr;
  logic                reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [WDATA_W-1:0]  reg_wdata;
  logic [RDATA_W-1:0]  reg_rdata;
  logic                range_sel, comp_en, smp_valid, energy_wrap;
  logic [AVG_W-1:0]    avg_code;
  logic [RES_W-1:0]    smp_shunt, smp_bus, calc_current;
  logic [TEMP_W-1:0]   smp_temp;
  logic [PWR_W-1:0]    calc_power;
  logic [ACC_W-1:0]    calc_energy, calc_charge;
  logic [CAL_W-1:0]    core_shunt_cal;
  logic [COEFF_W-1:0]  core_drift_coeff;
  logic                core_shunt_range, result_range, result_update, energy_overflow_flag;
  logic [39:0]         rdv, exp_res [7];
  logic                vld;
  pmrr_row_s           rows [15];
  int                  fail_count, checks_done, upd_cnt, cycles, base;

  pmrr_regs i_pmrr_regs (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .shunt_range_select(range_sel),
    .drift_compensation_enable(comp_en), .averaging_count(avg_code),
    .smp_valid(smp_valid), .smp_shunt(smp_shunt), .smp_bus(smp_bus), .smp_temp(smp_temp),
    .calc_current(calc_current), .calc_power(calc_power), .calc_energy(calc_energy),
    .calc_charge(calc_charge), .energy_wrap(energy_wrap), .core_shunt_cal(core_shunt_cal),
    .core_drift_coeff(core_drift_coeff), .core_shunt_range(core_shunt_range),
    .result_range(result_range), .result_update(result_update),
    .energy_overflow_flag(energy_overflow_flag));

  pmrr_host_model i_pmrr_host_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  // --------------------------------------------------------------------
  // Clock, watchdog, update counter
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    cycles++;
    if (result_update === 1'b1) upd_cnt++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Caller sits on a falling edge; consecutive calls give back-to-back strobes
  task automatic send(input logic [19:0] s, input logic [19:0] b, input logic [15:0] t);
    smp_valid = 1'b1;
    smp_shunt = s;
    smp_bus   = b;
    smp_temp  = t;
    @(negedge mclk);
  endtask : send

  task automatic idle(input int n);
    smp_valid = 1'b0;
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic check_results();
    for (int i = 0; i < 7; i++) begin
      i_pmrr_host_model.rd(6'(4 + i), rdv, vld);
      check("result word", rdv, exp_res[i]);
    end
  endtask : check_results

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; range_sel = 1'b0; comp_en = 1'b0; avg_code = 3'h0;
    smp_valid = 1'b0; smp_shunt = '0; smp_bus = '0; smp_temp = '0; energy_wrap = 1'b0;
    calc_current = '0; calc_power = '0; calc_energy = '0; calc_charge = '0;
    rows = '{'{1'b0, 6'h02, 16'h0, 40'h1000}, '{1'b0, 6'h03, 16'h0, 40'h0},
             '{1'b1, 6'h04, 16'hffff, 40'h0}, '{1'b1, 6'h05, 16'hffff, 40'h0},
             '{1'b1, 6'h06, 16'hffff, 40'h0}, '{1'b1, 6'h07, 16'hffff, 40'h0},
             '{1'b1, 6'h08, 16'hffff, 40'h0}, '{1'b1, 6'h09, 16'hffff, 40'h0},
             '{1'b1, 6'h0a, 16'hffff, 40'h0}, '{1'b1, 6'h02, 16'hffff, 40'h7fff},
             '{1'b1, 6'h02, 16'h8123, 40'h0123}, '{1'b1, 6'h03, 16'hffff, 40'h3fff},
             '{1'b1, 6'h03, 16'hc005, 40'h0005}, '{1'b1, 6'h00, 16'hffff, 40'h0},
             '{1'b1, 6'h3f, 16'hffff, 40'h0}};
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    check("cal after reset", {25'h0, core_shunt_cal}, 40'h1000);
    for (int i = 0; i < 15; i++) begin
      if (rows[i].wr) i_pmrr_host_model.wr(rows[i].addr, rows[i].wdata);
      i_pmrr_host_model.rd(rows[i].addr, rdv, vld);
      check("read valid", {39'h0, vld}, 40'h1);
      check("register word", rdv, rows[i].exp);
    end
    // Settings first, then conversions
    i_pmrr_host_model.wr(ADDR_CAL, 16'h0200);
    i_pmrr_host_model.wr(ADDR_COEFF, 16'h0019);
    @(negedge mclk);
    check("core cal", {25'h0, core_shunt_cal}, 40'h0200);
    check("coeff disabled", {26'h0, core_drift_coeff}, 40'h0);
    comp_en = 1'b1;
    range_sel = 1'b1;
    repeat (2) @(negedge mclk);
    check("coeff enabled", {26'h0, core_drift_coeff}, 40'h0019);
    check("core range", {39'h0, core_shunt_range}, 40'h1);
    // Single-sample capture with the narrow range
    calc_current = 20'h80001; calc_power = 24'hfedcba;
    calc_energy = 40'hff00000001; calc_charge = 40'h8000000002;
    base = upd_cnt;
    send(20'hfff85, 20'h12345, 16'h8001);
    idle(4);
    check("updates", 40'(upd_cnt - base), 40'h1);
    check("result range", {39'h0, result_range}, 40'h1);
    exp_res = '{40'hfff850, 40'h123450, 40'h8001, 40'h800010, 40'hfedcba,
                40'hff00000001, 40'h8000000002};
    check_results();
    // Four-sample average, wide range, floor on negatives
    avg_code = 3'h1; range_sel = 1'b0;
    calc_current = 20'h00010; calc_power = 24'h1; calc_energy = 40'h1;
    calc_charge = 40'hffffffffff;
    idle(2);
    base = upd_cnt;
    send(20'hfffff, 20'h100, 16'h1);
    send(20'hffffe, 20'h100, 16'h2);
    send(20'hffffe, 20'h100, 16'h3);
    idle(4);
    check("early update", 40'(upd_cnt - base), 40'h0);
    send(20'hffffe, 20'h100, 16'h4);
    idle(4);
    check("updates", 40'(upd_cnt - base), 40'h1);
    check("result range", {39'h0, result_range}, 40'h0);
    exp_res = '{40'hffffe0, 40'h1000, 40'h2, 40'h100, 40'h1, 40'h1, 40'hffffffffff};
    check_results();
    // Sixteen-sample average
    avg_code = 3'h2;
    idle(2);
    base = upd_cnt;
    repeat (15) send(20'h00010, 20'h00020, 16'h0003);
    idle(4);
    check("early update", 40'(upd_cnt - base), 40'h0);
    send(20'h00010, 20'h00020, 16'h0013);
    idle(4);
    check("updates", 40'(upd_cnt - base), 40'h1);
    i_pmrr_host_model.rd(ADDR_TEMP, rdv, vld);
    check("averaged temp", rdv, 40'h4);
    // Energy overflow flag: set, clear on read, set wins over clear
    energy_wrap = 1'b1;
    @(negedge mclk);
    energy_wrap = 1'b0;
    check("overflow set", {39'h0, energy_overflow_flag}, 40'h1);
    i_pmrr_host_model.rd(ADDR_ENERGY, rdv, vld);
    check("overflow cleared", {39'h0, energy_overflow_flag}, 40'h0);
    fork
      i_pmrr_host_model.rd(ADDR_ENERGY, rdv, vld);
      begin
        @(negedge mclk);
        energy_wrap = 1'b1;
        @(negedge mclk);
        energy_wrap = 1'b0;
      end
    join
    check("overflow kept", {39'h0, energy_overflow_flag}, 40'h1);
    // Second reset in mid-run restores the table
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    i_pmrr_host_model.rd(ADDR_CAL, rdv, vld);
    check("cal reset word", rdv, 40'h1000);
    check("overflow reset", {39'h0, energy_overflow_flag}, 40'h0);
    close_out();
  end

endmodule : pmrr_regs_tb_top
